// File: src/ocpc_codec.v
// coordinator-side builder and parser of command payloads
// Notes on behaviour
// [RL1] timer notice: id, 2-octet short address, 4-octet minimum update timer.
// [RL2] timer octets encoded exactly like the stored colour stab timer.
// [RL3] colour info: id, short address, three 2-octet levels, bands i j k.
// [RL4] band levels are linear, top code maximum, bottom code minimum.
// [RL5] band levels travel least significant octet first, rebuilt so.
// [RL6] device stops visibility frames after seeing usage bit zero.
// [RL7] device may resume visibility frames after usage bit one.
// [RL8] coordinator may clear usage bit to suppress interfering frames.
// [RL9] suppressed device may send out-of-band idle patterns instead.
// [RL10] visibility disable payload is one octet, bit 0 usage, rest reserved.
// [RL11] device sends usage bit one only while sending visibility frames.
// [RL12] element: one id octet, one length octet, then length octets.
// [RL13] elements are accepted in any order within a frame.
// [RL14] element id 0x01 is capabilities, 0x02 is wavelength quality.
// [RL15] elements follow the last field of the command format.
// [RL16] any command may carry several elements back to back.
// [RL17] capabilities payload: capability information then aggregation map.
// [RL18] capability information is 8 octets, bitmaps in whole octets.
// [RL19] device keeps a permission flag, reset permitted, set by usage bit.
// [RL20] unknown element ids are skipped by their length, parsing goes on.
`timescale 1ns/1ns
`include "ocpc_defs.vh"
module ocpc_codec #(
  parameter [7:0] CMD_ID_TIMER  = 8'h01,
  parameter [7:0] CMD_ID_COLOUR = 8'h02,
  parameter [7:0] CMD_ID_VISDIS = 8'h03,
  parameter       FIFO_DEPTH    = `OCPC_FIFO_DEPTH
) (
  input  wire        i_clk_sys,        // system clock, 250 MHz
  input  wire        i_reset_n,        // async reset, active low
  input  wire        i_clk_en,         // freezes all state when low
  input  wire        i_tx_start,       // start building a frame
  input  wire [1:0]  i_tx_kind,        // command kind
  input  wire        i_tx_add_cap,     // append capabilities element
  input  wire        i_tx_add_wqi,     // append wavelength quality element
  input  wire [15:0] i_tx_short_addr,  // short address field
  input  wire [31:0] i_tx_timer,       // colour stab timer attribute
  input  wire [15:0] i_tx_band_i,      // band i level
  input  wire [15:0] i_tx_band_j,      // band j level
  input  wire [15:0] i_tx_band_k,      // band k level
  input  wire        i_tx_allow_vis,   // wish to let device send frames
  input  wire        i_interference,   // visibility frames disturb link
  input  wire [63:0] i_tx_cap_info,    // capability information field
  input  wire [7:0]  i_tx_agg,         // aggregation bitmap octet
  input  wire [7:0]  i_tx_wqi,         // wavelength quality octet
  output wire        o_tx_start_ready, // builder idle
  output wire        o_tx_busy,        // frame being built
  output wire [7:0]  o_tx_data,        // outgoing octet
  output wire        o_tx_last,        // final octet of frame
  output wire        o_tx_valid,       // octet offered
  input  wire        i_tx_ready,       // link accepts octet
  input  wire [7:0]  i_rx_data,        // incoming octet
  input  wire        i_rx_valid,       // incoming octet valid
  input  wire        i_rx_last,        // final octet of frame
  output wire        o_rx_ready,       // parser accepts
  output reg         o_rx_timer_valid, // timer notice decoded
  output reg  [15:0] o_rx_short_addr,  // decoded short address
  output reg  [31:0] o_rx_timer,       // decoded timer field
  output reg         o_rx_colour_valid,// colour info decoded
  output reg  [15:0] o_rx_band_i,      // decoded band i
  output reg  [15:0] o_rx_band_j,      // decoded band j
  output reg  [15:0] o_rx_band_k,      // decoded band k
  output reg         o_rx_vis_valid,   // visibility disable decoded
  output reg         o_rx_usage_bit,   // peer usage bit, held
  output reg         o_rx_cap_valid,   // capability information decoded
  output reg  [63:0] o_rx_cap_info,    // decoded capability information
  output reg         o_rx_wqi_valid,   // wavelength quality decoded
  output reg  [7:0]  o_rx_wqi,         // first wavelength quality octet
  output reg         o_rx_ie_skipped,  // unknown element discarded
  output reg         o_rx_unknown_cmd, // unknown command id seen
  output reg         o_rx_frame_done,  // frame parsed cleanly
  output reg         o_rx_error        // frame ended inside a field
);
// ********************************************************************
// transmit sequencer
// ********************************************************************
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_CMD  = 2'h1;
  localparam [1:0] S_CAP  = 2'h2;
  localparam [1:0] S_WQI  = 2'h3;

  reg  [1:0]  t_state_reg;
  reg  [3:0]  t_idx_reg;
  reg  [1:0]  t_kind_reg;
  reg         t_cap_reg;
  reg         t_wqi_reg;
  reg  [15:0] t_addr_reg;
  reg  [31:0] t_timer_reg;
  reg  [47:0] t_bands_reg;
  reg         t_usage_reg;
  reg  [63:0] t_cap_info_reg;
  reg  [7:0]  t_agg_reg;
  reg  [7:0]  t_wqi_byte_reg;
  reg  [3:0]  sect_len;
  wire [7:0]  t_byte;
  wire        f_wr_ready;
  wire        push;
  wire        sect_end;
  wire        frame_end;
  wire [8:0]  f_rd_word;

  always @*
  begin
    case (t_state_reg)
      S_CMD:
      begin
        case (t_kind_reg)
          `OCPC_KIND_TIMER:  sect_len = `OCPC_LEN_TIMER;
          `OCPC_KIND_COLOUR: sect_len = `OCPC_LEN_COLOUR;
          default:           sect_len = `OCPC_LEN_VISDIS;
        endcase
      end
      S_CAP:   sect_len = `OCPC_LEN_CAP_IE;
      S_WQI:   sect_len = `OCPC_LEN_WQI_IE;
      default: sect_len = 4'h1;
    endcase
  end

  // the fifo's ready stalls the sequencer, so the link can back-pressure
  assign push      = i_clk_en & (t_state_reg != S_IDLE) & f_wr_ready;
  assign sect_end  = (t_idx_reg == sect_len - 4'h1);
  assign frame_end = sect_end &
                     ((t_state_reg == S_WQI) ||
                      (t_state_reg == S_CAP && !t_wqi_reg) ||
                      (t_state_reg == S_CMD && !t_cap_reg && !t_wqi_reg));
  assign o_tx_start_ready = (t_state_reg == S_IDLE);
  assign o_tx_busy        = (t_state_reg != S_IDLE);

  always @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      t_state_reg    <= S_IDLE;
      t_idx_reg      <= 4'h0;
      t_kind_reg     <= `OCPC_KIND_TIMER;
      t_cap_reg      <= 1'b0;
      t_wqi_reg      <= 1'b0;
      t_addr_reg     <= 16'h0000;
      t_timer_reg    <= 32'h0000_0000;
      t_bands_reg    <= 48'h0;
      t_usage_reg    <= 1'b1;
      t_cap_info_reg <= 64'h0;
      t_agg_reg      <= 8'h00;
      t_wqi_byte_reg <= 8'h00;
    end
    else if (i_clk_en)
    begin
      if (t_state_reg == S_IDLE && i_tx_start)
      begin
        t_state_reg    <= S_CMD;
        t_idx_reg      <= 4'h0;
        t_kind_reg     <= i_tx_kind;
        t_cap_reg      <= i_tx_add_cap;                       // [RL16]
        t_wqi_reg      <= i_tx_add_wqi;
        t_addr_reg     <= i_tx_short_addr;
        t_timer_reg    <= i_tx_timer;                          // [RL2]
        t_bands_reg    <= {i_tx_band_k, i_tx_band_j, i_tx_band_i};
        // interference forces the device off visibility frames
        t_usage_reg    <= i_tx_allow_vis & ~i_interference;    // [RL8]
        t_cap_info_reg <= i_tx_cap_info;
        t_agg_reg      <= i_tx_agg;
        t_wqi_byte_reg <= i_tx_wqi;
      end
      else if (push)
      begin
        if (!sect_end)
          t_idx_reg <= t_idx_reg + 4'h1;
        else
        begin
          t_idx_reg <= 4'h0;
          // elements only after the command's own last field
          case (t_state_reg)
            S_CMD:   t_state_reg <= t_cap_reg ? S_CAP :
                                    (t_wqi_reg ? S_WQI : S_IDLE); // [RL15]
            S_CAP:   t_state_reg <= t_wqi_reg ? S_WQI : S_IDLE;
            default: t_state_reg <= S_IDLE;
          endcase
        end
      end
    end
  end

  ocpc_tx_format #(
    .CMD_ID_TIMER  (CMD_ID_TIMER),
    .CMD_ID_COLOUR (CMD_ID_COLOUR),
    .CMD_ID_VISDIS (CMD_ID_VISDIS)
  ) u_format (
    .i_sect     (t_state_reg - 2'h1),
    .i_idx      (t_idx_reg),
    .i_kind     (t_kind_reg),
    .i_addr     (t_addr_reg),
    .i_timer    (t_timer_reg),
    .i_bands    (t_bands_reg),
    .i_usage    (t_usage_reg),
    .i_cap_info (t_cap_info_reg),
    .i_agg      (t_agg_reg),
    .i_wqi      (t_wqi_byte_reg),
    .o_byte     (t_byte)
  );

  ocpc_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_reset_n  (i_reset_n),
    .i_clk_en   (i_clk_en),
    .i_wr_data  ({frame_end, t_byte}),
    .i_wr_valid (push),
    .o_wr_ready (f_wr_ready),
    .o_rd_data  (f_rd_word),
    .o_rd_valid (o_tx_valid),
    .i_rd_ready (i_tx_ready)
  );

  assign o_tx_data = f_rd_word[7:0];
  assign o_tx_last = f_rd_word[8];

// ********************************************************************
// receive parser
// ********************************************************************
  localparam [2:0] P_CMD    = 3'h0;
  localparam [2:0] P_BODY   = 3'h1;
  localparam [2:0] P_IE_ID  = 3'h2;
  localparam [2:0] P_IE_LEN = 3'h3;
  localparam [2:0] P_IE_PAY = 3'h4;
  localparam [2:0] P_DROP   = 3'h5;

  reg  [2:0]  p_state_reg;
  reg  [1:0]  p_kind_reg;
  reg  [7:0]  p_body_len_reg;
  reg  [7:0]  p_cnt_reg;
  reg  [7:0]  p_ie_id_reg;
  reg  [7:0]  p_ie_len_reg;
  reg  [71:0] p_body_reg;
  reg  [63:0] p_cap_reg;
  wire        take;
  wire [71:0] body_sh;
  wire [63:0] cap_sh;
  wire [7:0]  cnt_inc;

  assign o_rx_ready = i_clk_en;
  assign take       = i_rx_valid & i_clk_en;
  // octets arrive low first, so shift each in at the top
  assign body_sh    = {i_rx_data, p_body_reg[71:8]};               // [RL5]
  assign cap_sh     = {i_rx_data, p_cap_reg[63:8]};
  assign cnt_inc    = p_cnt_reg + 8'h01;

  always @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      p_state_reg       <= P_CMD;
      p_kind_reg        <= `OCPC_KIND_TIMER;
      p_body_len_reg    <= 8'h00;
      p_cnt_reg         <= 8'h00;
      p_ie_id_reg       <= 8'h00;
      p_ie_len_reg      <= 8'h00;
      p_body_reg        <= 72'h0;
      p_cap_reg         <= 64'h0;
      o_rx_timer_valid  <= 1'b0;
      o_rx_short_addr   <= 16'h0000;
      o_rx_timer        <= 32'h0000_0000;
      o_rx_colour_valid <= 1'b0;
      o_rx_band_i       <= 16'h0000;
      o_rx_band_j       <= 16'h0000;
      o_rx_band_k       <= 16'h0000;
      o_rx_vis_valid    <= 1'b0;
      o_rx_usage_bit    <= 1'b1;
      o_rx_cap_valid    <= 1'b0;
      o_rx_cap_info     <= 64'h0;
      o_rx_wqi_valid    <= 1'b0;
      o_rx_wqi          <= 8'h00;
      o_rx_ie_skipped   <= 1'b0;
      o_rx_unknown_cmd  <= 1'b0;
      o_rx_frame_done   <= 1'b0;
      o_rx_error        <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_rx_timer_valid  <= 1'b0;
      o_rx_colour_valid <= 1'b0;
      o_rx_vis_valid    <= 1'b0;
      o_rx_cap_valid    <= 1'b0;
      o_rx_wqi_valid    <= 1'b0;
      o_rx_ie_skipped   <= 1'b0;
      o_rx_unknown_cmd  <= 1'b0;
      o_rx_frame_done   <= 1'b0;
      o_rx_error        <= 1'b0;
      if (take)
      begin
        case (p_state_reg)
          P_CMD:
          begin
            p_cnt_reg <= 8'h00;
            if (i_rx_data == CMD_ID_TIMER || i_rx_data == CMD_ID_COLOUR ||
                i_rx_data == CMD_ID_VISDIS)
            begin
              p_kind_reg     <= (i_rx_data == CMD_ID_TIMER) ?
                                `OCPC_KIND_TIMER :
                                (i_rx_data == CMD_ID_COLOUR) ?
                                `OCPC_KIND_COLOUR : `OCPC_KIND_VISDIS;
              p_body_len_reg <= (i_rx_data == CMD_ID_TIMER) ?
                                `OCPC_BODY_TIMER :
                                (i_rx_data == CMD_ID_COLOUR) ?
                                `OCPC_BODY_COLOUR : `OCPC_BODY_VISDIS;
              p_state_reg    <= i_rx_last ? P_CMD : P_BODY;
              o_rx_error     <= i_rx_last;
            end
            else
            begin
              // body layout unknown, so element boundaries cannot be found
              o_rx_unknown_cmd <= 1'b1;
              p_state_reg      <= i_rx_last ? P_CMD : P_DROP;
            end
          end
          P_BODY:
          begin
            p_body_reg <= body_sh;
            p_cnt_reg  <= cnt_inc;
            if (cnt_inc == p_body_len_reg)
            begin
              case (p_kind_reg)
                `OCPC_KIND_TIMER:
                begin
                  o_rx_short_addr  <= body_sh[39:24];              // [RL1]
                  o_rx_timer       <= body_sh[71:40];              // [RL2]
                  o_rx_timer_valid <= 1'b1;
                end
                `OCPC_KIND_COLOUR:
                begin
                  o_rx_short_addr   <= body_sh[23:8];              // [RL3]
                  o_rx_band_i       <= body_sh[39:24];             // [RL4]
                  o_rx_band_j       <= body_sh[55:40];
                  o_rx_band_k       <= body_sh[71:56];
                  o_rx_colour_valid <= 1'b1;
                end
                default:
                begin
                  // reserved bits are ignored on reception
                  o_rx_usage_bit <= body_sh[64 + `OCPC_USAGE_BIT]; // [RL11]
                  o_rx_vis_valid <= 1'b1;                          // [RL10]
                end
              endcase
              o_rx_frame_done <= i_rx_last;
              p_state_reg     <= i_rx_last ? P_CMD : P_IE_ID;      // [RL15]
            end
            else if (i_rx_last)
            begin
              o_rx_error  <= 1'b1;
              p_state_reg <= P_CMD;
            end
          end
          P_IE_ID:
          begin
            // any id may come in any position, no ordering is enforced
            p_ie_id_reg <= i_rx_data;                          // [RL13]
            o_rx_error  <= i_rx_last;
            p_state_reg <= i_rx_last ? P_CMD : P_IE_LEN;       // [RL12]
          end
          P_IE_LEN:
          begin
            p_ie_len_reg <= i_rx_data;
            p_cnt_reg    <= 8'h00;
            if (i_rx_data == 8'h00)
            begin
              o_rx_frame_done <= i_rx_last;
              p_state_reg     <= i_rx_last ? P_CMD : P_IE_ID;
            end
            else
            begin
              o_rx_error  <= i_rx_last;
              p_state_reg <= i_rx_last ? P_CMD : P_IE_PAY;
            end
          end
          P_IE_PAY:
          begin
            p_cnt_reg <= cnt_inc;
            if (p_ie_id_reg == `OCPC_IE_CAP &&
                p_cnt_reg < `OCPC_CAP_INFO_LEN)
            begin
              p_cap_reg <= cap_sh;                             // [RL17]
              if (cnt_inc == `OCPC_CAP_INFO_LEN)
              begin
                o_rx_cap_info  <= cap_sh;                      // [RL18]
                o_rx_cap_valid <= 1'b1;
              end
            end
            if (p_ie_id_reg == `OCPC_IE_WQI && p_cnt_reg == 8'h00)
            begin
              o_rx_wqi       <= i_rx_data;                     // [RL14]
              o_rx_wqi_valid <= 1'b1;
            end
            if (cnt_inc == p_ie_len_reg)
            begin
              o_rx_ie_skipped <= (p_ie_id_reg != `OCPC_IE_CAP) &&
                                 (p_ie_id_reg != `OCPC_IE_WQI); // [RL20]
              o_rx_frame_done <= i_rx_last;
              p_state_reg     <= i_rx_last ? P_CMD : P_IE_ID;  // [RL16]
            end
            else if (i_rx_last)
            begin
              o_rx_error  <= 1'b1;
              p_state_reg <= P_CMD;
            end
          end
          default:
          begin
            if (i_rx_last)
              p_state_reg <= P_CMD;
          end
        endcase
      end
    end
  end
endmodule // ocpc_codec

// File: src/ocpc_defs.vh
// shared constants of the optical mac command payload codec
`ifndef OCPC_DEFS_VH
`define OCPC_DEFS_VH
// ********************************************************************
// command kinds requested on the transmit side
// ********************************************************************
`define OCPC_KIND_TIMER    2'h0
`define OCPC_KIND_COLOUR   2'h1
`define OCPC_KIND_VISDIS   2'h2
// ********************************************************************
// octet counts on the wire, identifier octet included
// ********************************************************************
`define OCPC_LEN_TIMER     4'h7
`define OCPC_LEN_COLOUR    4'h9
`define OCPC_LEN_VISDIS    4'h2
`define OCPC_LEN_CAP_IE    4'hb
`define OCPC_LEN_WQI_IE    4'h3
// ********************************************************************
// payload octets after the identifier octet
// ********************************************************************
`define OCPC_BODY_TIMER    8'h06
`define OCPC_BODY_COLOUR   8'h08
`define OCPC_BODY_VISDIS   8'h01
// ********************************************************************
// information elements
// ********************************************************************
`define OCPC_IE_CAP        8'h01
`define OCPC_IE_WQI        8'h02
`define OCPC_CAP_INFO_LEN  8'h08
`define OCPC_CAP_PAY_LEN   8'h09
`define OCPC_WQI_PAY_LEN   8'h01
`define OCPC_USAGE_BIT     0
`define OCPC_FIFO_DEPTH    4
`endif

// File: src/ocpc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module ocpc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_clk_sys,  // system clock
  input  wire             i_reset_n,  // async reset, active low
  input  wire             i_clk_en,   // freezes state when low
  input  wire [WIDTH-1:0] i_wr_data,  // word to store
  input  wire             i_wr_valid, // word offered
  output wire             o_wr_ready, // room left
  output reg  [WIDTH-1:0] o_rd_data,  // oldest word
  output wire             o_rd_valid, // word available
  input  wire             i_rd_ready  // drain side accepts
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_wr;
  wire            do_rd;

  assign o_wr_ready = (count_reg != DEPTH[AW:0]);
  assign o_rd_valid = (count_reg != {(AW+1){1'b0}});
  assign do_wr      = i_clk_en & i_wr_valid & o_wr_ready;
  assign do_rd      = i_clk_en & o_rd_valid & i_rd_ready;

  always @*
  begin
    o_rd_data = mem_reg[rd_ptr_reg];
  end

  always @(posedge i_clk_sys)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg] <= i_wr_data;
  end

  always @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (do_wr & ~do_rd)
        count_reg <= count_reg + 1'b1;
      else if (do_rd & ~do_wr)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // ocpc_fifo

// File: src/ocpc_tx_format.v
// octet selector for outgoing command payloads and elements
`timescale 1ns/1ns
`include "ocpc_defs.vh"
module ocpc_tx_format #(
  parameter [7:0] CMD_ID_TIMER  = 8'h01,
  parameter [7:0] CMD_ID_COLOUR = 8'h02,
  parameter [7:0] CMD_ID_VISDIS = 8'h03
) (
  input  wire [1:0]  i_sect,      // 0 command, 1 cap element, 2 wqi
  input  wire [3:0]  i_idx,       // octet index within section
  input  wire [1:0]  i_kind,      // command kind
  input  wire [15:0] i_addr,      // short address
  input  wire [31:0] i_timer,     // colour stab timer attribute value
  input  wire [47:0] i_bands,     // {k, j, i} band levels
  input  wire        i_usage,     // visibility frame usage bit
  input  wire [63:0] i_cap_info,  // capability information field
  input  wire [7:0]  i_agg,       // aggregation bitmap, one octet
  input  wire [7:0]  i_wqi,       // wavelength quality octet
  output reg  [7:0]  o_byte       // selected octet
);
  reg [87:0] vec;

  // every multi-octet field goes out least significant octet first
  always @*
  begin
    vec = 88'h0;
    case (i_sect)
      2'h0:
      begin
        case (i_kind)
          `OCPC_KIND_TIMER:  vec = {32'h0, i_timer, i_addr,
                                    CMD_ID_TIMER};            // [RL1] [RL2]
          `OCPC_KIND_COLOUR: vec = {16'h0, i_bands, i_addr,
                                    CMD_ID_COLOUR};      // [RL3] [RL4] [RL5]
          default:           vec = {72'h0, 7'h00, i_usage,
                                    CMD_ID_VISDIS};           // [RL10]
        endcase
      end
      2'h1: vec = {i_agg, i_cap_info, `OCPC_CAP_PAY_LEN,
                   `OCPC_IE_CAP};                  // [RL12] [RL17] [RL18]
      2'h2: vec = {64'h0, i_wqi, `OCPC_WQI_PAY_LEN, `OCPC_IE_WQI}; // [RL14]
      default: vec = 88'h0;
    endcase
    o_byte = vec[{i_idx, 3'h0} +: 8];
  end
endmodule // ocpc_tx_format

// File: verif/ocpc_codec_monitor.sv
// checker on the codec ports
`timescale 1ns/1ns
module ocpc_codec_monitor (
  input wire logic i_clk_sys, i_reset_n, i_clk_en, i_tx_start, i_tx_ready,
  input wire logic o_tx_start_ready, o_tx_busy, o_tx_valid, o_tx_last,
  input wire logic i_rx_valid, i_rx_last, o_rx_vis_valid, o_rx_usage_bit,
  input wire logic o_rx_frame_done, o_rx_error, o_rx_unknown_cmd,
  input wire logic [7:0] o_tx_data, i_rx_data
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  start_busy_a: assert property (i_tx_start && o_tx_start_ready
    && i_clk_en |=> o_tx_busy ##1 o_tx_valid) else $error("no start");
  idle_busy_a: assert property (o_tx_start_ready != o_tx_busy)
    else $error("idle and busy");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
    && $stable(o_tx_data) && $stable(o_tx_last)) else $error("octet moved");
  busy_end_a: assert property ($rose(o_tx_busy) |-> ##[1:300] !o_tx_busy)
    else $error("frame stuck");
  usage_copy_a: assert property (o_rx_vis_valid
    |-> o_rx_usage_bit == $past(i_rx_data[0])) else $error("usage bit");
  usage_keep_a: assert property (!$stable(o_rx_usage_bit)
    |-> o_rx_vis_valid) else $error("usage moved");
  frame_end_a: assert property (o_rx_frame_done || o_rx_error
    |-> $past(i_rx_valid && i_rx_last)) else $error("frame end");
  drop_cmd_a: assert property (o_rx_unknown_cmd |-> !o_rx_frame_done)
    else $error("dropped frame done");
  cover property ($fell(o_tx_busy));
  cover property (o_rx_vis_valid && !o_rx_usage_bit);
  cover property (o_rx_error);
endmodule // ocpc_codec_monitor

// File: verif/ocpc_codec_tb_top.sv
// bench: codec against device model and queue model
`timescale 1ns/1ns
module ocpc_codec_tb_top;
  logic i_clk_sys = 0, i_reset_n = 0, i_clk_en = 1, i_tx_start = 0, u, z;
  logic i_tx_add_cap, i_tx_add_wqi, i_tx_allow_vis, i_interference;
  logic i_rx_valid = 0, i_rx_last = 0, stall = 0;
  logic [1:0] i_tx_kind;
  logic [7:0] i_tx_agg, i_tx_wqi, i_rx_data = 0, q[$];
  logic [15:0] i_tx_short_addr, i_tx_band_i, i_tx_band_j, i_tx_band_k;
  logic [31:0] i_tx_timer;
  logic [63:0] i_tx_cap_info;
  wire i_tx_ready, o_tx_start_ready, o_tx_busy, o_tx_last, o_tx_valid, vis;
  wire o_rx_ready, o_rx_timer_valid, o_rx_colour_valid, o_rx_vis_valid;
  wire o_rx_usage_bit, o_rx_cap_valid, o_rx_wqi_valid, o_rx_ie_skipped;
  wire o_rx_unknown_cmd, o_rx_frame_done, o_rx_error;
  wire [7:0] o_tx_data, o_rx_wqi;
  wire [15:0] o_rx_short_addr, o_rx_band_i, o_rx_band_j, o_rx_band_k;
  wire [31:0] o_rx_timer;
  wire [63:0] o_rx_cap_info;
  int num_errors = 0, n_tests = 0, t;
  ocpc_codec u_ocpc_codec (.*);
  ocpc_dev_model u_ocpc_dev_model (.i_clk_sys, .i_reset_n, .i_data(o_tx_data),
    .i_valid(o_tx_valid), .i_last(o_tx_last), .i_stall(stall),
    .o_ready(i_tx_ready), .o_vis_on(vis), .o_idle_on());
  initial forever #2 i_clk_sys = ~i_clk_sys;
  task automatic cmp(input string n, input logic [63:0] e, g);
    n_tests++;
    if (e !== g) $display("mismatch %s exp %h got %h", n, e, g);
    if (e !== g) num_errors++;
  endtask
  task automatic put(input logic [63:0] v, input int n);
    for (int b = 0; b < n; b++) q.push_back(v[8*b +: 8]);
  endtask
  // x adds an unknown element, o puts wqi before cap
  task automatic mk(input logic [1:0] k, input logic c, w, x, o);
    q = {};
    z = !(c | w | x);
    put(k > 1 ? 3 : k + 1, 1);
    put(i_tx_short_addr, k < 2 ? 2 : 0);
    put(i_tx_timer, k == 0 ? 4 : 0);
    put({i_tx_band_k, i_tx_band_j, i_tx_band_i}, k == 1 ? 6 : 0);
    put(u, k > 1);
    put(32'h55aa027f, x ? 4 : 0);
    put({i_tx_wqi, 16'h0102}, w && o ? 3 : 0);
    put(16'h0901, c ? 2 : 0);
    put(i_tx_cap_info, c ? 8 : 0);
    put(i_tx_agg, c);
    put({i_tx_wqi, 16'h0102}, w && !o ? 3 : 0);
  endtask
  task automatic rnd();
    {i_tx_short_addr, i_tx_timer} = {$urandom, $urandom};
    {i_tx_band_i, i_tx_band_j} = $urandom;
    {i_tx_band_k, i_tx_agg, i_tx_wqi} = $urandom;
    i_tx_cap_info = {$urandom, $urandom};
    {i_tx_kind, i_tx_add_cap, i_tx_add_wqi, i_tx_allow_vis, i_interference}
      = $urandom;
    u = i_tx_allow_vis & ~i_interference;
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    t = $urandom(32'hc0981a8c);
    rnd();
    repeat (4) @(negedge i_clk_sys);
    i_reset_n = 1;
    cmp("usage rst", 1, o_rx_usage_bit);
    for (int f = 0; f < 14; f++)
    begin
      rnd();
      stall = f == 3;
      t = f > 7 ? $urandom : 0;
      mk(i_tx_kind, i_tx_add_cap, i_tx_add_wqi, t[0], t[1]);
      if (f > 11) q = {f > 12 ? 8'h01 : 8'hee};
      if (f < 8)
      begin
        i_tx_start = 1;
        @(negedge i_clk_sys) i_tx_start = 0;
        for (t = 0; t < 400 && u_ocpc_dev_model.got.size() < q.size(); t++)
          @(negedge i_clk_sys) stall = stall && t < 30;
        if (t == 400) num_errors++;
        if (t == 400) end_of_test();
        foreach (q[i]) cmp("tx", q[i], u_ocpc_dev_model.got[i]);
        if (i_tx_kind > 1) cmp("vis", u, vis);
        u_ocpc_dev_model.got = {};
      end
      else
      begin
        foreach (q[i])
        begin
          {i_rx_data, i_rx_valid, i_rx_last} = {q[i], 1'h1, i == q.size() - 1};
          @(negedge i_clk_sys);
        end
        {i_rx_valid, i_rx_last} = 0;
        cmp("end", {f < 12, f == 12, f > 12},
          {o_rx_frame_done, o_rx_unknown_cmd, o_rx_error});
        if (f > 11) continue;
        if (i_tx_kind < 2) cmp("addr", i_tx_short_addr, o_rx_short_addr);
        if (i_tx_kind == 0)
          cmp("tmr", {z, i_tx_timer}, {o_rx_timer_valid, o_rx_timer});
        if (i_tx_kind == 1) cmp("bands", {z, i_tx_band_k, i_tx_band_j,
          i_tx_band_i}, {o_rx_colour_valid, o_rx_band_k, o_rx_band_j, o_rx_band_i});
        if (i_tx_kind > 1) cmp("use", {z, u}, {o_rx_vis_valid, o_rx_usage_bit});
        if (i_tx_add_cap) cmp("cap", i_tx_cap_info, o_rx_cap_info);
        if (i_tx_add_wqi) cmp("wqi", i_tx_wqi, o_rx_wqi);
      end
    end
    end_of_test();
  end
endmodule // ocpc_codec_tb_top
bind ocpc_codec ocpc_codec_monitor u_ocpc_codec_monitor (.*);

// File: verif/ocpc_dev_model.sv
// device model: takes octets, keeps visibility flag
`timescale 1ns/1ns
module ocpc_dev_model (
  input  wire logic       i_clk_sys, // clock
  input  wire logic       i_reset_n, // reset
  input  wire logic [7:0] i_data,    // octet
  input  wire logic       i_valid,   // offered
  input  wire logic       i_last,    // frame end
  input  wire logic       i_stall,   // hold off
  output logic            o_ready,   // accepts
  output logic            o_vis_on,  // sends vis frames
  output logic            o_idle_on  // idle pattern
);
  logic [7:0] frm[$], got[$];
  logic       vis_ok_reg;
  // random stalls: a real device is rarely always ready
  initial o_ready = 1'h0;
  always @(negedge i_clk_sys) o_ready <= !i_stall && $urandom % 3 > 0;
  assign o_vis_on = vis_ok_reg;
  assign o_idle_on = !vis_ok_reg;
  always @(posedge i_clk_sys or negedge i_reset_n)
    if (!i_reset_n) vis_ok_reg <= 1'h1;
    else if (i_valid && o_ready)
    begin
      got.push_back(i_data);
      frm.push_back(i_data);
      if (i_last && frm[0] == 8'h03) vis_ok_reg <= frm[1][0];
      if (i_last) frm = {};
    end
endmodule // ocpc_dev_model
